// [fbrl_pkg.sv]
package fbrl_pkg;

  // ------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------
  localparam logic [7:0] BURST_SAMPLE_COUNT_ADDR = 8'h4B;
  localparam logic [7:0] BURST_SAMPLE_COUNT_RST = 8'h06;
  localparam logic [7:0] REG_UNMAPPED_DATA = 8'h00;

  // ------------------------------------------------------------
  // Sample layout
  // ------------------------------------------------------------
  localparam int RECORD_BYTES = 6;
  localparam int MAX_STATUS_BYTES = 2;
  localparam int MAX_SAMPLE_BYTES = RECORD_BYTES + MAX_STATUS_BYTES;
  localparam logic [3:0] RECORD_BYTES_W = 4'h6;
  localparam logic [3:0] MAX_SAMPLE_BYTES_W = 4'h8;
  localparam logic [1:0] STATUS_SEL_MAX = 2'h2;
  localparam int FIFO_DEPTH = 8;

  typedef struct packed {
    logic [15:0] z;
    logic [15:0] y;
    logic [15:0] x;
  } fbrl_record_t;

  typedef struct packed {
    logic [7:0] status_b;
    logic [7:0] status_a;
    fbrl_record_t record;
  } fbrl_sample_t;

  typedef enum logic [1:0] {
    FBRL_IDLE,
    FBRL_WAIT,
    FBRL_SEND
  } fbrl_state_t;

endpackage

// [fbrl_top.sv]
// What this block does
// RL1: 8-bit read/write burst sample count at 0x4B, power-on value 0x06.
// RL2: With burst enabled, one burst delivers exactly the programmed sample count.
// RL3: Each sample is 6 record bytes plus zero, one or two status bytes.
// RL4: Count means whole samples; burst bytes equal count times sample size.
// RL5: With burst disabled the count is ignored and affects no read.
// RL6: New count applies to the next burst; reads return last written value.
`timescale 1ns/100ps

module fbrl_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW:0] FULL_LEVEL = (AW+1)'(DEPTH);
  localparam logic [AW-1:0] LAST_SLOT = AW'(DEPTH - 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] level;
  logic push;
  logic pop;

  assign in_ready = (level != FULL_LEVEL);
  assign out_valid = (level != '0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem[rd_ptr];

  function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
    bump = (p == LAST_SLOT) ? '0 : AW'(p + 1'b1);
  endfunction

  always_ff @(posedge clk)
  begin
    if (push)
    begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      level <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr <= bump(wr_ptr);
      end
      if (pop)
      begin
        rd_ptr <= bump(rd_ptr);
      end
      if (push && !pop)
      begin
        level <= level + 1'b1;
      end
      else if (pop && !push)
      begin
        level <= level - 1'b1;
      end
    end
  end
endmodule

module fbrl_top #(
  parameter int FIFO_DEPTH = fbrl_pkg::FIFO_DEPTH
) (
  // Clock and reset
  input wire logic I_SYS_CLK,
  input wire logic I_RESETN,
  // Register port from the serial interface
  input wire logic [7:0] I_REG_ADDR,
  input wire logic I_REG_WR,
  input wire logic I_REG_RD,
  input wire logic [7:0] I_REG_WDATA,
  output logic [7:0] O_REG_RDATA,
  // Burst control
  input wire logic I_BURST_EN,
  input wire logic [1:0] I_STATUS_SEL,
  input wire logic [7:0] I_STATUS_A,
  input wire logic [7:0] I_STATUS_B,
  input wire logic I_BURST_START,
  output logic O_BURST_BUSY,
  output logic O_BURST_DONE,
  // Samples from the FIFO store
  input wire fbrl_pkg::fbrl_record_t I_RECORD,
  input wire logic I_RECORD_VALID,
  output logic O_RECORD_READY,
  // Byte stream to the serial interface
  output logic [7:0] O_BYTE,
  output logic O_BYTE_VALID,
  input wire logic I_BYTE_READY
);

  // ------------------------------------------------------------
  // Register
  // ------------------------------------------------------------
  logic [7:0] burst_sample_count;

  always_ff @(posedge I_SYS_CLK or negedge I_RESETN)
  begin
    if (!I_RESETN)
    begin
      burst_sample_count <= fbrl_pkg::BURST_SAMPLE_COUNT_RST; // RL1
    end
    else if (I_REG_WR && I_REG_ADDR == fbrl_pkg::BURST_SAMPLE_COUNT_ADDR)
    begin
      burst_sample_count <= I_REG_WDATA; // RL1 RL6
    end
  end

  always_ff @(posedge I_SYS_CLK or negedge I_RESETN)
  begin
    if (!I_RESETN)
    begin
      O_REG_RDATA <= fbrl_pkg::REG_UNMAPPED_DATA;
    end
    else if (I_REG_RD)
    begin
      O_REG_RDATA <= (I_REG_ADDR == fbrl_pkg::BURST_SAMPLE_COUNT_ADDR) ?
        burst_sample_count : fbrl_pkg::REG_UNMAPPED_DATA; // RL6
    end
  end

  // ------------------------------------------------------------
  // Burst sequencer
  // ------------------------------------------------------------
  function automatic logic [3:0] sample_len(input logic [1:0] sel);
    logic [1:0] n;
    n = (sel > fbrl_pkg::STATUS_SEL_MAX) ? fbrl_pkg::STATUS_SEL_MAX : sel;
    sample_len = fbrl_pkg::RECORD_BYTES_W + {2'b00, n};
  endfunction

  fbrl_pkg::fbrl_state_t state;
  fbrl_pkg::fbrl_sample_t sample;
  logic [7:0] samples_left;
  logic [3:0] byte_len;
  logic [3:0] byte_idx;
  logic fifo_ready;
  logic push;
  logic last_byte;
  logic [7:0] cur_byte;

  assign O_RECORD_READY = (state == fbrl_pkg::FBRL_WAIT);
  assign O_BURST_BUSY = (state != fbrl_pkg::FBRL_IDLE);
  assign push = (state == fbrl_pkg::FBRL_SEND);
  assign last_byte = (byte_idx == byte_len - 4'h1);
  assign cur_byte = sample[8*byte_idx[2:0] +: 8];

  // Sample size and count are frozen at burst start so a register write
  // in mid-burst cannot change the length of the burst already running.
  always_ff @(posedge I_SYS_CLK or negedge I_RESETN)
  begin
    if (!I_RESETN)
    begin
      state <= fbrl_pkg::FBRL_IDLE;
      samples_left <= '0;
      byte_len <= fbrl_pkg::RECORD_BYTES_W;
      byte_idx <= '0;
      sample <= '0;
      O_BURST_DONE <= 1'b0;
    end
    else
    begin
      O_BURST_DONE <= 1'b0;
      unique case (state)
        fbrl_pkg::FBRL_IDLE:
        begin
          if (I_BURST_START && I_BURST_EN) // RL5
          begin
            samples_left <= burst_sample_count; // RL6
            byte_len <= sample_len(I_STATUS_SEL); // RL3
            if (burst_sample_count == '0)
            begin
              O_BURST_DONE <= 1'b1;
            end
            else
            begin
              state <= fbrl_pkg::FBRL_WAIT;
            end
          end
        end
        fbrl_pkg::FBRL_WAIT:
        begin
          if (I_RECORD_VALID)
          begin
            sample <= {I_STATUS_B, I_STATUS_A, I_RECORD}; // RL3
            byte_idx <= '0;
            state <= fbrl_pkg::FBRL_SEND;
          end
        end
        fbrl_pkg::FBRL_SEND:
        begin
          if (fifo_ready)
          begin
            byte_idx <= byte_idx + 4'h1;
            if (last_byte)
            begin
              samples_left <= samples_left - 8'h01; // RL4
              if (samples_left == 8'h01)
              begin
                state <= fbrl_pkg::FBRL_IDLE; // RL2
                O_BURST_DONE <= 1'b1;
              end
              else
              begin
                state <= fbrl_pkg::FBRL_WAIT;
              end
            end
          end
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // Output buffer
  // ------------------------------------------------------------
  // The serial side may stall; the sequencer waits while it is full.
  fbrl_fifo #(
    .WIDTH(8),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(I_SYS_CLK),
    .resetn(I_RESETN),
    .in_valid(push),
    .in_ready(fifo_ready),
    .in_data(cur_byte),
    .out_valid(O_BYTE_VALID),
    .out_ready(I_BYTE_READY),
    .out_data(O_BYTE)
  );

endmodule

// [fbrl_props.sv]
`timescale 1ns/100ps
module fbrl_props (
  input wire logic I_SYS_CLK,
  input wire logic I_RESETN,
  input wire logic [7:0] I_REG_ADDR,
  input wire logic I_REG_WR,
  input wire logic I_REG_RD,
  input wire logic [7:0] I_REG_WDATA,
  input wire logic [7:0] O_REG_RDATA,
  input wire logic I_BURST_EN,
  input wire logic O_BURST_BUSY,
  input wire logic O_BURST_DONE,
  input wire logic O_RECORD_READY,
  input wire logic I_RECORD_VALID,
  input wire logic [7:0] O_BYTE,
  input wire logic O_BYTE_VALID,
  input wire logic I_BYTE_READY
);
  default clocking cb @(posedge I_SYS_CLK); endclocking
  default disable iff (!I_RESETN);
  property p_unmap;
    I_REG_RD && I_REG_ADDR != 8'h4B |=> O_REG_RDATA == 8'h00;
  endproperty
  a_unmap: assert property (p_unmap) else $error("bad unmapped");
  property p_wr_rd;
    I_REG_WR && I_REG_ADDR == 8'h4B ##1 I_REG_RD && !I_REG_WR &&
      I_REG_ADDR == 8'h4B |=> O_REG_RDATA == $past(I_REG_WDATA, 2);
  endproperty
  a_wr_rd: assert property (p_wr_rd) else $error("bad readback");
  property p_dis;
    !I_BURST_EN && !O_BURST_BUSY |=> !O_BURST_BUSY;
  endproperty
  a_dis: assert property (p_dis) else $error("busy while off");
  property p_end;
    $fell(O_BURST_BUSY) |-> O_BURST_DONE;
  endproperty
  a_end: assert property (p_end) else $error("no done");
  // A taken record is followed by at least six cycles with O_RECORD_READY low
  property p_rec;
    O_RECORD_READY && I_RECORD_VALID |=> !O_RECORD_READY [*6];
  endproperty
  a_rec: assert property (p_rec) else $error("stray take");
  property p_hold;
    O_BYTE_VALID && !I_BYTE_READY |=> O_BYTE_VALID && $stable(O_BYTE);
  endproperty
  a_hold: assert property (p_hold) else $error("byte lost");
endmodule

// [fbrl_host_model.sv]
`timescale 1ns/100ps
module fbrl_host_model (
  input wire logic i_clk,
  input wire logic i_slow,
  input wire logic [7:0] i_byte,
  input wire logic i_byte_valid,
  output fbrl_pkg::fbrl_record_t o_rec,
  output logic o_rec_valid,
  output logic o_byte_ready,
  output int o_n_bytes,
  output logic [7:0] o_last
);
  logic [1:0] tick = 2'h0;
  int n_bytes = 0;
  assign o_n_bytes = n_bytes;
  assign o_rec = '{z: 16'h5554, y: 16'h3332, x: 16'h1110};
  assign o_rec_valid = 1'b1;
  // Slow host takes one byte in four so the FIFO fills
  assign o_byte_ready = !i_slow || tick == 2'h3;
  always_ff @(posedge i_clk)
  begin
    tick <= tick + 2'h1;
    if (i_byte_valid && o_byte_ready)
    begin
      n_bytes <= n_bytes + 1;
      o_last <= i_byte;
    end
  end
endmodule

// [fbrl_top_tb_top.sv]
`timescale 1ns/100ps
module fbrl_top_tb_top;
  typedef struct packed {
    logic [7:0] c;
    logic [1:0] s;
    logic w;
    logic [7:0] n;
    logic [7:0] l;
  } fbrl_row_t;
  logic clk = 0, rstn = 0, wr = 0, rd = 0, en = 0, start = 0, slow = 0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, obyte, last;
  logic [1:0] sel = 2'h0;
  logic busy, done, rrdy, bval, brdy, rval;
  fbrl_pkg::fbrl_record_t rec;
  int num_errors = 0, n_tests = 0, cyc = 0, nb, i;
  // Count, status select, slow host, expected bytes, expected last byte
  fbrl_row_t rows [4] = '{'{8'h06, 2'h0, 1'h1, 8'h24, 8'h55},
    '{8'h01, 2'h1, 1'h0, 8'h07, 8'hA7}, '{8'h03, 2'h2, 1'h1, 8'h18, 8'hB9},
    '{8'h02, 2'h3, 1'h0, 8'h10, 8'hB9}};
  initial forever #4 clk = !clk;
  fbrl_top u_fbrl_top (.I_SYS_CLK(clk), .I_RESETN(rstn), .I_REG_ADDR(addr),
    .I_REG_WR(wr), .I_REG_RD(rd), .I_REG_WDATA(wdata), .O_REG_RDATA(rdata),
    .I_BURST_EN(en), .I_STATUS_SEL(sel), .I_STATUS_A(8'hA7),
    .I_STATUS_B(8'hB9), .I_BURST_START(start), .O_BURST_BUSY(busy),
    .O_BURST_DONE(done), .I_RECORD(rec), .I_RECORD_VALID(rval),
    .O_RECORD_READY(rrdy), .O_BYTE(obyte), .O_BYTE_VALID(bval),
    .I_BYTE_READY(brdy));
  fbrl_host_model u_fbrl_host_model (.i_clk(clk), .i_slow(slow),
    .i_byte(obyte), .i_byte_valid(bval), .o_rec(rec), .o_rec_valid(rval),
    .o_byte_ready(brdy), .o_n_bytes(nb), .o_last(last));
  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    n_tests++;
    if (g !== e)
    begin
      num_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic chkn(input int g, input int e);
    n_tests++;
    if (g != e)
    begin
      num_errors++;
      $display("[FAIL] %0t bytes %0d exp %0d", $time, g, e);
    end
  endtask
  task automatic reg_op(input logic w, input logic [7:0] a,
    input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= w;
    rd <= !w;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b0;
    #1;
  endtask
  task automatic burst(input int e);
    int k, n0;
    n0 = nb;
    @(posedge clk);
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    #1;
    chk8({7'h00, busy}, {7'h00, e != 0});
    for (k = 0; k < 300 && done !== 1'b1; k++) #8;
    chk8({7'h00, done}, {7'h00, en});
    for (k = 0; k < 200 && bval !== 1'b0; k++) #8;
    chkn(nb - n0, e);
  endtask
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      num_errors++;
      end_sim();
    end
  end
  initial
  begin
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    reg_op(1'b0, 8'h4B, 8'h00);
    chk8(rdata, fbrl_pkg::BURST_SAMPLE_COUNT_RST);
    reg_op(1'b0, 8'h4A, 8'h00);
    chk8(rdata, 8'h00);
    en <= 1'b1;
    for (i = 0; i < 4; i++)
    begin
      sel <= rows[i].s;
      slow <= rows[i].w;
      reg_op(1'b1, 8'h4B, rows[i].c);
      burst(rows[i].n);
      chk8(last, rows[i].l);
      $display("row %0d done", i);
    end
    @(posedge clk);
    addr <= 8'h4B;
    wdata <= 8'h02;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk8(rdata, 8'h02);
    // A write on the start edge must not change the running burst
    fork
      burst(16);
      reg_op(1'b1, 8'h4B, 8'h05);
    join
    $display("mid-burst write done");
    en <= 1'b0;
    burst(0);
    en <= 1'b1;
    reg_op(1'b1, 8'h4B, 8'h00);
    burst(0);
    $display("edge cases done");
    @(posedge clk);
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    reg_op(1'b0, 8'h4B, 8'h00);
    chk8(rdata, fbrl_pkg::BURST_SAMPLE_COUNT_RST);
    $display("reset test done");
    end_sim();
  end
endmodule
bind fbrl_top fbrl_props u_fbrl_props (.I_SYS_CLK(I_SYS_CLK),
  .I_RESETN(I_RESETN), .I_REG_ADDR(I_REG_ADDR), .I_REG_WR(I_REG_WR),
  .I_REG_RD(I_REG_RD), .I_REG_WDATA(I_REG_WDATA), .O_REG_RDATA(O_REG_RDATA),
  .I_BURST_EN(I_BURST_EN), .O_BURST_BUSY(O_BURST_BUSY),
  .O_BURST_DONE(O_BURST_DONE), .O_RECORD_READY(O_RECORD_READY),
  .I_RECORD_VALID(I_RECORD_VALID),
  .O_BYTE(O_BYTE), .O_BYTE_VALID(O_BYTE_VALID), .I_BYTE_READY(I_BYTE_READY));
